/* File: core/spr_change_detect.sv */
/*
  Change detector: one-cycle pulse whenever a group of level inputs differs
  from its value on the previous edge.
  Assumes inputs synchronous to clk_in; no pulse on the first edge after reset.
*/
`default_nettype none
module spr_change_detect #(
  parameter int unsigned W = 3               // Width of watched group
) (
  input  wire logic         clk_in,          // System clock
  input  wire logic         sys_rst_in,      // Synchronous reset, active high
  input  wire logic [W-1:0] val_in,          // Levels to watch
  output logic              changed_out      // Pulse on any change
);
  // Refuse an empty group
  if (W < 1) begin : g_chk
    $error("spr_change_detect: W must be at least 1");
  end

  typedef struct packed {
    logic [W-1:0] prev;    // Value seen on the last edge
    logic         primed;  // Prev holds a real sample
  } spr_cd_state_t;

  spr_cd_state_t st;       // Registered state
  spr_cd_state_t next_st;  // Next state

  // Sample the group; primed keeps a level present at reset from pulsing
  always_comb begin
    next_st        = st;
    next_st.prev   = val_in;
    next_st.primed = 1'b1;
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign changed_out = st.primed && (val_in != st.prev);
endmodule : spr_change_detect
`default_nettype wire

/* File: core/spr_pkg.sv */
/*
  Constants and carrier types for the synthesizer profile register bank:
  serial and parallel addresses, reset values, field widths and the packed
  structs that hold the buffered and the active register sets.
  Assumes nothing beyond a SystemVerilog elaborator.
*/
`default_nettype none
package spr_pkg;
  // Profile count served by two select inputs
  localparam int unsigned SPR_NUM_PROFILES = 4;
  localparam int unsigned SPR_SEL_W        = 2;
  localparam int unsigned SPR_POW_W        = 14;

  // Serial register addresses
  localparam logic [5:0] SPR_SER_CFR       = 6'h00;
  localparam logic [5:0] SPR_SER_STEP      = 6'h01;
  localparam logic [5:0] SPR_SER_RAMP      = 6'h02;
  localparam logic [5:0] SPR_SER_PROF_BASE = 6'h03;  // Tuning word, profile 0
  localparam logic [5:0] SPR_SER_PROF_LAST = 6'h0a;  // Phase word, profile 3

  // Parallel byte addresses
  localparam logic [5:0] SPR_PAR_CFR_LAST  = 6'h03;
  localparam logic [5:0] SPR_PAR_STEP_LAST = 6'h07;
  localparam logic [5:0] SPR_PAR_RAMP_LO   = 6'h08;
  localparam logic [5:0] SPR_PAR_RAMP_HI   = 6'h09;
  localparam logic [5:0] SPR_PAR_PROF_BASE = 6'h0a;  // Tuning word byte 0, profile 0
  localparam logic [5:0] SPR_PAR_PROF_LAST = 6'h21;  // Phase word high byte, profile 3
  localparam logic [5:0] SPR_PROF_BYTES    = 6'h06;  // Bytes per profile group

  // Byte offsets inside one profile group
  localparam logic [2:0] SPR_OFF_POW_LO    = 3'h4;
  localparam logic [2:0] SPR_OFF_POW_HI    = 3'h5;

  // Reset values
  localparam logic [31:0] SPR_CFR_RESET    = 32'h0000_0018;
  localparam logic [31:0] SPR_WORD_RESET   = 32'h0000_0000;

  // One profile group
  typedef struct packed {
    logic [31:0]          tuning_word;
    logic [SPR_POW_W-1:0] phase_offset;
  } spr_profile_t;

  // Whole buffered register set
  typedef struct packed {
    logic [31:0]                              control_function;
    logic [31:0]                              sweep_step_word;
    logic [15:0]                              sweep_ramp_rate;
    spr_profile_t [SPR_NUM_PROFILES-1:0]      prof;
  } spr_bank_t;

  // Values the synthesizer core runs on
  typedef struct packed {
    logic [31:0]          control_function;
    logic [31:0]          sweep_step_word;
    logic [15:0]          sweep_ramp_rate;
    logic [31:0]          tuning_word;
    logic [SPR_POW_W-1:0] phase_offset;
  } spr_core_t;
endpackage : spr_pkg
`default_nettype wire

/* File: core/spr_register_bank.sv */
/*
  Profile register bank of a direct digital synthesizer: buffered registers
  written byte-wise over the parallel port or word-wise over the serial port,
  read back on both, and copied into the active core set on update.
  Assumes both ports have already been deserialised to single-cycle strobes
  synchronous to clk_in, and that the host uses one port at a time.
*/
// What this block does
// - Registers decoded by serial word and parallel byte
// - Profile-0 tuning word, bytes 0x0A-0x0D, resets zero
// - Profile-1 tuning word, bytes 0x10-0x13, high last
// - Profile-0 phase word, 14 bits, bytes 0x0E-0x0F
// - Ramp rate 16 bits, bytes 0x08-0x09, shared
// - Profile selects pick group for reads, address is offset; writes take the group from the address
// - Update strobe toggle or select change loads core
// - Lowest parallel byte carries bits 7:0
`default_nettype none
module spr_register_bank
  import spr_pkg::*;
(
  input  wire logic        clk_in,                 // System clock, 100 MHz
  input  wire logic        sys_rst_in,             // Synchronous reset, active high
  input  wire logic [5:0]  par_addr_in,            // Parallel byte address
  input  wire logic        par_wr_in,              // Parallel write strobe
  input  wire logic [7:0]  par_wr_data_in,         // Parallel write byte
  input  wire logic        par_rd_in,              // Parallel read strobe
  output logic [7:0]       par_rd_data_out,        // Parallel read byte
  output logic             par_data_oe_n_out,      // Low while data pins driven
  input  wire logic [5:0]  ser_addr_in,            // Serial register address
  input  wire logic        ser_wr_in,              // Serial word write strobe
  input  wire logic [31:0] ser_wr_data_in,         // Serial word, low bits used
  input  wire logic        ser_rd_in,              // Serial read strobe
  output logic [31:0]      ser_rd_data_out,        // Serial read word
  output logic             ser_rd_valid_out,       // Read word fresh this cycle
  input  wire logic        frequency_update_strobe_in,
  input  wire logic        profile_select_low_in,
  input  wire logic        profile_select_high_in,
  output spr_core_t        core_out                // Active core values
);
  typedef struct packed {
    spr_bank_t   buffer;       // Host-visible buffered set
    spr_core_t   core;         // Set the core runs on
    logic [7:0]  par_rd_data;  // Held parallel read byte
    logic        par_drive;    // Parallel data pins driven
    logic [31:0] ser_rd_data;  // Held serial read word
    logic        ser_rd_valid; // Serial read answered
  } spr_state_t;

  spr_state_t                st;        // Registered state
  spr_state_t                next_st;   // Next state
  logic [SPR_SEL_W-1:0]      sel_now;   // Current profile select
  logic                      upd_pulse; // Load the core this edge
  logic [5:0]                par_rel;   // Offset into profile area
  logic [SPR_SEL_W-1:0]      par_prof;  // Profile named by parallel address
  logic [2:0]                par_off;   // Byte inside that profile
  logic [5:0]                ser_rel;   // Offset into serial profile area
  logic [SPR_SEL_W-1:0]      ser_prof;  // Profile named by serial address
  logic                      par_in_prof;
  logic                      ser_in_prof;
  logic [7:0]                par_byte;  // Parallel read mux
  logic [31:0]               ser_word;  // Serial read mux
  spr_profile_t              sel_prof;  // Buffered group picked by selects

  assign sel_now  = {profile_select_high_in, profile_select_low_in};
  assign sel_prof = st.buffer.prof[sel_now];

  // Strobe level toggle or any select change raises the load pulse
  spr_change_detect #(
    .W (3)
  ) u_update (
    .clk_in      (clk_in),
    .sys_rst_in  (sys_rst_in),
    .val_in      ({frequency_update_strobe_in, sel_now}),
    .changed_out (upd_pulse)
  );

  // Address split for the profile areas of both ports
  always_comb begin
    par_rel     = 6'(par_addr_in - SPR_PAR_PROF_BASE);
    par_prof    = SPR_SEL_W'(par_rel / SPR_PROF_BYTES);
    par_off     = 3'(par_rel % SPR_PROF_BYTES);
    ser_rel     = 6'(ser_addr_in - SPR_SER_PROF_BASE);
    ser_prof    = SPR_SEL_W'(ser_rel >> 1);
    par_in_prof = (par_addr_in >= SPR_PAR_PROF_BASE) && (par_addr_in <= SPR_PAR_PROF_LAST);
    ser_in_prof = (ser_addr_in >= SPR_SER_PROF_BASE) && (ser_addr_in <= SPR_SER_PROF_LAST);
  end

  // Parallel readback; profile area follows the selects, address is offset
  always_comb begin
    par_byte = 8'h00;                                        // Unmapped reads zero
    if (par_addr_in <= SPR_PAR_CFR_LAST) begin
      par_byte = st.buffer.control_function[8*par_addr_in[1:0] +: 8];
    end else if (par_addr_in <= SPR_PAR_STEP_LAST) begin
      par_byte = st.buffer.sweep_step_word[8*par_addr_in[1:0] +: 8];
    end else if (par_addr_in == SPR_PAR_RAMP_LO) begin
      par_byte = st.buffer.sweep_ramp_rate[7:0];
    end else if (par_addr_in == SPR_PAR_RAMP_HI) begin
      par_byte = st.buffer.sweep_ramp_rate[15:8];
    end else if (par_in_prof) begin
      if (par_off == SPR_OFF_POW_LO) begin
        par_byte = sel_prof.phase_offset[7:0];
      end else if (par_off == SPR_OFF_POW_HI) begin
        par_byte = {2'b00, sel_prof.phase_offset[13:8]};     // Top bits unused
      end else begin
        par_byte = sel_prof.tuning_word[8*par_off[1:0] +: 8];
      end
    end
  end

  // Serial readback of whole registers, low bits justified
  always_comb begin
    ser_word = 32'h0000_0000;                                // Unmapped reads zero
    unique case (ser_addr_in)
      SPR_SER_CFR:  ser_word = st.buffer.control_function;
      SPR_SER_STEP: ser_word = st.buffer.sweep_step_word;
      SPR_SER_RAMP: ser_word = {16'h0000, st.buffer.sweep_ramp_rate};
      default: begin
        if (ser_in_prof && ser_rel[0]) begin
          ser_word = {18'h00000, sel_prof.phase_offset};
        end else if (ser_in_prof) begin
          ser_word = sel_prof.tuning_word;
        end
      end
    endcase
  end

  // Next state: serial write, then parallel write, reads, core load
  always_comb begin
    next_st              = st;
    next_st.ser_rd_valid = 1'b0;
    // Serial writes reach the whole register at once
    if (ser_wr_in) begin
      unique case (ser_addr_in)
        SPR_SER_CFR:  next_st.buffer.control_function = ser_wr_data_in;
        SPR_SER_STEP: next_st.buffer.sweep_step_word  = ser_wr_data_in;
        SPR_SER_RAMP: next_st.buffer.sweep_ramp_rate  = ser_wr_data_in[15:0];
        default: begin
          if (ser_in_prof && ser_rel[0]) begin
            next_st.buffer.prof[ser_prof].phase_offset = ser_wr_data_in[13:0];
          end else if (ser_in_prof) begin
            next_st.buffer.prof[ser_prof].tuning_word = ser_wr_data_in;
          end
        end
      endcase
    end
    // Parallel writes reach one byte; applied last so it wins a collision
    if (par_wr_in) begin
      if (par_addr_in <= SPR_PAR_CFR_LAST) begin
        next_st.buffer.control_function[8*par_addr_in[1:0] +: 8] = par_wr_data_in;
      end else if (par_addr_in <= SPR_PAR_STEP_LAST) begin
        next_st.buffer.sweep_step_word[8*par_addr_in[1:0] +: 8] = par_wr_data_in;
      end else if (par_addr_in == SPR_PAR_RAMP_LO) begin
        next_st.buffer.sweep_ramp_rate[7:0] = par_wr_data_in;
      end else if (par_addr_in == SPR_PAR_RAMP_HI) begin
        next_st.buffer.sweep_ramp_rate[15:8] = par_wr_data_in;
      end else if (par_in_prof) begin
        if (par_off == SPR_OFF_POW_LO) begin
          next_st.buffer.prof[par_prof].phase_offset[7:0] = par_wr_data_in;
        end else if (par_off == SPR_OFF_POW_HI) begin
          next_st.buffer.prof[par_prof].phase_offset[13:8] = par_wr_data_in[5:0];
        end else begin
          // Lowest address carries bits 7:0
          next_st.buffer.prof[par_prof].tuning_word[8*par_off[1:0] +: 8] =
            par_wr_data_in;
        end
      end
    end
    // Reads are answered one edge later and held until the next read
    if (par_rd_in) begin
      next_st.par_rd_data = par_byte;
    end
    next_st.par_drive = par_rd_in;
    if (ser_rd_in) begin
      next_st.ser_rd_data  = ser_word;
      next_st.ser_rd_valid = 1'b1;
    end
    // Core sees the buffer as it stood before any same-edge write
    if (upd_pulse) begin
      next_st.core.control_function = st.buffer.control_function;
      next_st.core.sweep_step_word  = st.buffer.sweep_step_word;
      next_st.core.sweep_ramp_rate  = st.buffer.sweep_ramp_rate;
      next_st.core.tuning_word      = sel_prof.tuning_word;
      next_st.core.phase_offset     = sel_prof.phase_offset;
    end
  end

  // State register; core and buffer share reset values
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st                                <= '0;
      st.buffer.control_function        <= SPR_CFR_RESET;
      st.core.control_function          <= SPR_CFR_RESET;
      st.buffer.prof[0].tuning_word     <= SPR_WORD_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign par_rd_data_out   = st.par_rd_data;
  assign par_data_oe_n_out = ~st.par_drive;
  assign ser_rd_data_out   = st.ser_rd_data;
  assign ser_rd_valid_out  = st.ser_rd_valid;
  assign core_out          = st.core;

  // Checks
  a_cfr_reset_value: assert property (@(posedge clk_in)
    $past(sys_rst_in) |->
      st.buffer.control_function == SPR_CFR_RESET && core_out.control_function == SPR_CFR_RESET)
    else $error("control function not 0x18 after reset");

  a_tuning_word_profile0_low_byte: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    par_wr_in && par_addr_in == 6'h0a |=>
      st.buffer.prof[0].tuning_word[7:0] == $past(par_wr_data_in))
    else $error("byte 0x0a did not land in tuning word 0 bits 7:0");

  a_tuning_word_profile1_high_byte: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    par_wr_in && par_addr_in == 6'h13 |=>
      st.buffer.prof[1].tuning_word[31:24] == $past(par_wr_data_in))
    else $error("byte 0x13 did not land in tuning word 1 bits 31:24");

  a_pow_top_zero: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    par_rd_in && par_addr_in == 6'h0f |=> par_rd_data_out[7:6] == 2'b00 && !par_data_oe_n_out)
    else $error("phase word high byte unused bits not zero");

  a_ramp_serial_write: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ser_wr_in && ser_addr_in == 6'h02 && !par_wr_in |=>
      st.buffer.sweep_ramp_rate == $past(ser_wr_data_in[15:0]))
    else $error("serial ramp rate write lost");

  a_ser_read_offset: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ser_rd_in && ser_addr_in == 6'h03 |=>
      ser_rd_valid_out && ser_rd_data_out ==
        $past(st.buffer.prof[{profile_select_high_in, profile_select_low_in}].tuning_word))
    else $error("serial read ignored profile selects");

  a_core_holds: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !upd_pulse |=> $stable(core_out))
    else $error("core changed without update");

  a_core_loads: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $changed(frequency_update_strobe_in) && !$past(sys_rst_in) |=>
      core_out.tuning_word == $past(sel_prof.tuning_word)
      && core_out.control_function == $past(st.buffer.control_function))
    else $error("update toggle did not load core");
endmodule : spr_register_bank
`default_nettype wire

/* File: tb/spr_host_model.sv */
/*
  Host controller model for the profile register bank: drives the parallel and
  serial strobes, the update strobe and the profile selects, and collects reads.
  Assumes a free-running clk_in; every request is launched and ended on a
  falling edge, so the bank's rising edge samples a steady request.
*/
`default_nettype none
module spr_host_model (
  input  wire logic        clk_in,           // System clock
  output logic [5:0]       par_addr_out,     // Parallel byte address
  output logic             par_wr_out,       // Parallel write strobe
  output logic [7:0]       par_wr_data_out,  // Parallel write byte
  output logic             par_rd_out,       // Parallel read strobe
  input  wire logic [7:0]  par_rd_data_in,   // Parallel read byte
  input  wire logic        par_data_oe_n_in, // Low while bank drives data
  output logic [5:0]       ser_addr_out,     // Serial register address
  output logic             ser_wr_out,       // Serial write strobe
  output logic [31:0]      ser_wr_data_out,  // Serial write word
  output logic             ser_rd_out,       // Serial read strobe
  input  wire logic [31:0] ser_rd_data_in,   // Serial read word
  input  wire logic        ser_rd_valid_in,  // Serial read word fresh
  output logic             upd_out,          // Update strobe level
  output logic [1:0]       sel_out           // Profile selects {high,low}
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle levels from time zero
  initial begin
    par_addr_out    = 6'h00;
    par_wr_out      = 1'b0;
    par_wr_data_out = 8'h00;
    par_rd_out      = 1'b0;
    ser_addr_out    = 6'h00;
    ser_wr_out      = 1'b0;
    ser_wr_data_out = 32'h0000_0000;
    ser_rd_out      = 1'b0;
    upd_out         = 1'b0;
    sel_out         = 2'h0;
  end

  // One byte write; the released data bus shows the inverse, never a stale copy
  task automatic par_wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk_in);
    par_addr_out    = a;
    par_wr_data_out = d;
    par_wr_out      = 1'b1;
    @(negedge clk_in);
    par_wr_out      = 1'b0;
    par_wr_data_out = ~d;
  endtask

  // One byte read; data and enable are taken one cycle after the strobe
  task automatic par_rd(input logic [5:0] a, output logic [7:0] d, output logic oe_n);
    @(negedge clk_in);
    par_addr_out = a;
    par_rd_out   = 1'b1;
    @(negedge clk_in);
    par_rd_out = 1'b0;
    d          = par_rd_data_in;
    oe_n       = par_data_oe_n_in;
  endtask

  // Whole-register serial write, word right-justified
  task automatic ser_wr(input logic [5:0] a, input logic [31:0] d);
    @(negedge clk_in);
    ser_addr_out    = a;
    ser_wr_data_out = d;
    ser_wr_out      = 1'b1;
    @(negedge clk_in);
    ser_wr_out      = 1'b0;
    ser_wr_data_out = ~d;
  endtask

  // Whole-register serial read; valid stands for one cycle only
  task automatic ser_rd(input logic [5:0] a, output logic [31:0] d, output logic v);
    @(negedge clk_in);
    ser_addr_out = a;
    ser_rd_out   = 1'b1;
    @(negedge clk_in);
    ser_rd_out = 1'b0;
    d          = ser_rd_data_in;
    v          = ser_rd_valid_in;
  endtask

  // Set update strobe and selects; core is settled at the task's end
  task automatic set_ctl(input logic u, input logic [1:0] s);
    @(negedge clk_in);
    upd_out = u;
    sel_out = s;
    @(negedge clk_in);
  endtask
endmodule // spr_host_model
`default_nettype wire

/* File: tb/tb.sv */
/*
  Self-checking bench for the profile register bank: reset values, byte
  layout, profile selection, core update and refused addresses.
  Assumes spr_pkg and the host model are compiled first.
*/
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import spr_pkg::*;

  logic        clk_in;      // 100 MHz clock
  logic        sys_rst_in;  // Synchronous reset
  logic [5:0]  pa, sa;      // Parallel and serial addresses
  logic        pw, pr, sw, sr, pv, svld, upd;
  logic [7:0]  pwd, prd;    // Parallel data both ways
  logic [31:0] swd, srd;    // Serial data both ways
  logic [1:0]  sel;         // Profile selects
  spr_core_t   core;        // Active core values
  int          failures;    // Mismatch count
  int          n_tests;     // Comparison count
  int          cycles;      // Hang guard
  int          i;

  spr_register_bank spr_register_bank_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .par_addr_in(pa), .par_wr_in(pw), .par_wr_data_in(pwd), .par_rd_in(pr),
    .par_rd_data_out(prd), .par_data_oe_n_out(pv), .ser_addr_in(sa), .ser_wr_in(sw),
    .ser_wr_data_in(swd), .ser_rd_in(sr), .ser_rd_data_out(srd), .ser_rd_valid_out(svld),
    .frequency_update_strobe_in(upd), .profile_select_low_in(sel[0]),
    .profile_select_high_in(sel[1]), .core_out(core));

  spr_host_model spr_host_model_i (.clk_in(clk_in), .par_addr_out(pa), .par_wr_out(pw),
    .par_wr_data_out(pwd), .par_rd_out(pr), .par_rd_data_in(prd), .par_data_oe_n_in(pv),
    .ser_addr_out(sa), .ser_wr_out(sw), .ser_wr_data_out(swd), .ser_rd_out(sr),
    .ser_rd_data_in(srd), .ser_rd_valid_in(svld), .upd_out(upd), .sel_out(sel));

  // Clock generator
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      stop_test();
    end
  end

  // Single comparison on any value, zero-extended to a word
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Parallel read: byte must match and data pins must be driven
  task automatic chk_par(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       oe_n;
    spr_host_model_i.par_rd(a, d, oe_n);
    cmp({24'h0, d}, {24'h0, e});
    cmp({31'h0, oe_n}, 32'h0);
  endtask

  // Serial read: word must match with valid raised
  task automatic chk_ser(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic        v;
    spr_host_model_i.ser_rd(a, d, v);
    cmp(d, e);
    cmp({31'h0, v}, 32'h1);
  endtask

  // Verdict and end of run
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Main sequence
  initial begin
    failures   = 0;
    n_tests    = 0;
    cycles     = 0;
    sys_rst_in = 1'b1;
    repeat (12) @(negedge clk_in);
    sys_rst_in = 1'b0;
    // Reset values over the serial map, then low control byte in parallel
    for (i = 0; i <= 10; i++) chk_ser(6'(i), (i == 0) ? 32'h18 : 32'h0);
    chk_par(6'h00, 8'h18);
    cmp(core.control_function, 32'h18);
    $display("test reset done");
    // Profile-0 words written byte-wise, read back whole
    for (i = 0; i < 4; i++) spr_host_model_i.par_wr(6'h0a + 6'(i), 8'(8'h11 * (i + 1)));
    chk_ser(6'h03, 32'h4433_2211);
    chk_par(6'h0d, 8'h44);
    spr_host_model_i.par_wr(6'h0e, 8'ha5);
    spr_host_model_i.par_wr(6'h0f, 8'hff);
    chk_ser(6'h04, 32'h3fa5);
    chk_par(6'h0f, 8'h3f);
    cmp(core.tuning_word, 32'h0);
    $display("test profile0 done");
    // Shared words written whole, read byte-wise low byte first
    spr_host_model_i.ser_wr(6'h02, 32'hffff_1234);
    spr_host_model_i.ser_wr(6'h00, 32'h0102_0318);
    spr_host_model_i.ser_wr(6'h01, 32'hcafe_0001);
    chk_par(6'h08, 8'h34);
    chk_par(6'h09, 8'h12);
    for (i = 0; i < 4; i++) chk_par(6'(i), 8'(32'h0102_0318 >> (8 * i)));
    for (i = 0; i < 4; i++) chk_par(6'(4 + i), 8'(32'hcafe_0001 >> (8 * i)));
    $display("test shared done");
    // Strobe toggle copies the buffer into the core
    spr_host_model_i.set_ctl(1'b1, 2'h0);
    cmp(core.tuning_word, 32'h4433_2211);
    cmp({18'h0, core.phase_offset}, 32'h3fa5);
    cmp({16'h0, core.sweep_ramp_rate}, 32'h1234);
    cmp(core.control_function, 32'h0102_0318);
    cmp(core.sweep_step_word, 32'hcafe_0001);
    $display("test update done");
    // Profile 1: select change alone updates, reads use offset plus selects
    for (i = 0; i < 4; i++) spr_host_model_i.par_wr(6'h10 + 6'(i), 8'(8'ha0 + i));
    cmp(core.tuning_word, 32'h4433_2211);
    chk_ser(6'h03, 32'h4433_2211);
    spr_host_model_i.set_ctl(1'b1, 2'h1);
    cmp(core.tuning_word, 32'ha3a2_a1a0);
    cmp({18'h0, core.phase_offset}, 32'h0);
    chk_ser(6'h03, 32'ha3a2_a1a0);
    chk_par(6'h0a, 8'ha0);
    chk_par(6'h0d, 8'ha3);
    chk_ser(6'h02, 32'h1234);
    // Profile 3 by serial; high select alone, then low select alone, reload the core
    spr_host_model_i.ser_wr(6'h09, 32'h1357_9bdf);
    spr_host_model_i.ser_wr(6'h0a, 32'hffff_2abc);
    cmp(core.tuning_word, 32'ha3a2_a1a0);
    spr_host_model_i.set_ctl(1'b1, 2'h3);
    cmp(core.tuning_word, 32'h1357_9bdf);
    cmp({18'h0, core.phase_offset}, 32'h2abc);
    chk_par(6'h0e, 8'hbc);
    chk_ser(6'h04, 32'h2abc);
    spr_host_model_i.set_ctl(1'b1, 2'h2);
    cmp(core.tuning_word, 32'h0);
    spr_host_model_i.set_ctl(1'b0, 2'h0);
    cmp(core.tuning_word, 32'h4433_2211);
    $display("test profile1 done");
    // Addresses outside the map take no write and read as zero
    spr_host_model_i.par_wr(6'h22, 8'h5a);
    spr_host_model_i.ser_wr(6'h0b, 32'h5a5a_5a5a);
    chk_par(6'h22, 8'h00);
    chk_ser(6'h0b, 32'h0);
    chk_ser(6'h03, 32'h4433_2211);
    chk_ser(6'h00, 32'h0102_0318);
    $display("test refused done");
    stop_test();
  end
endmodule // tb
`default_nettype wire
